// File: hdl/lps_floor_clamp.sv
// Floor clamp: maps the four-bit floor code through a logarithmic table.
// Assumes the requested current code comes from the photo regulator on the same clock.
module lps_floor_clamp
	import lps_pkg::*;
(
	// Inputs.
	input  wire logic [lps_pkg::FLOOR_W-1:0] i_code,
	input  wire logic [lps_pkg::CUR_W-1:0]   i_req,
	input  wire logic                        i_active,
	// Output.
	output logic      [lps_pkg::CUR_W-1:0]   o_cur
);
	import lps_pkg::*;

	logic [CUR_W-1:0] floor_val; // Current floor after the table.

	// Table roughly doubles every two codes; code zero still gives one step so o_cur never drops to zero while regulation runs.
	always_comb begin
		case (i_code)
			4'h0: floor_val = 8'h01;
			4'h1: floor_val = 8'h02;
			4'h2: floor_val = 8'h03;
			4'h3: floor_val = 8'h04;
			4'h4: floor_val = 8'h06;
			4'h5: floor_val = 8'h08;
			4'h6: floor_val = 8'h0b;
			4'h7: floor_val = 8'h10;
			4'h8: floor_val = 8'h16;
			4'h9: floor_val = 8'h20;
			4'ha: floor_val = 8'h2d;
			4'hb: floor_val = 8'h40;
			4'hc: floor_val = 8'h5a;
			4'hd: floor_val = 8'h80;
			4'he: floor_val = 8'hb5;
			default: floor_val = 8'hff;
		endcase
	end

	// Raise the request to the floor only while regulation runs.
	always_comb begin
		o_cur = i_req;
		if (i_active && (i_req < floor_val)) begin
			o_cur = floor_val;
		end
	end
endmodule : lps_floor_clamp

// File: hdl/lps_pkg.sv
// Package for the segment PWM sequencer and ambient-light floor core.
// Assumes a single 25 MHz clock and registers loaded by the serial port logic outside.
package lps_pkg;
	// Register widths and field layout.
	localparam int          REG_W          = 8;     // Every control register is one byte.
	localparam int          DUTY_W         = 5;     // Duty field, bits 4 to 0.
	localparam int          FLOOR_W        = 4;     // Floor code, bits 3 to 0.
	localparam int          CUR_W          = 8;     // Width of the regulated current code.
	localparam int          NCH            = 3;     // Number of segment channels.
	localparam logic [7:0]  FLOOR_RESET    = 8'h00; // Floor register reset value.
	localparam logic [7:0]  FLOOR_MASK     = 8'h0f; // Reserved upper bits read as zero.
	// PWM frame: 32 slots of 3.125 percent each.
	localparam logic [4:0]  SLOT_LAST      = 5'h1f; // Last slot of a frame.
	localparam logic [4:0]  DUTY_FULL      = 5'h1f; // Highest duty code, treated as full power.
	// Strategy codes on the two-bit configuration input.
	localparam logic [1:0]  STRAT_SYNC     = 2'h0;  // All channels locked together.
	localparam logic [1:0]  STRAT_CHAIN    = 2'h1;  // Each waits for the previous at full power.
	localparam logic [1:0]  STRAT_INDEP    = 2'h2;  // Shared ramp, independent enables.
	localparam logic [1:0]  STRAT_FREE     = 2'h3;  // Arbitrary duty and timing.
	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		SQ_OFF  = 3'b001,
		SQ_MAIN = 3'b010,
		SQ_RUN  = 3'b100
	} lps_seq_e;
endpackage : lps_pkg

// File: hdl/lps_seq_core.sv
// Segment PWM sequencer with undervoltage shutdown and ambient floor.
// Assumes byte registers are written by the serial port logic on the same clock,
// and that the lockout and main-display flags arrive asynchronously from analog.
module lps_seq_core
	import lps_pkg::*;
(
	// Clock and reset.
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_sys_rst,
	// Register port.
	input  wire logic                       i_floor_we,
	input  wire logic [lps_pkg::REG_W-1:0]  i_floor_wdata,
	input  wire logic [lps_pkg::REG_W-1:0]  i_duty_a,
	input  wire logic [lps_pkg::REG_W-1:0]  i_duty_b,
	input  wire logic [lps_pkg::REG_W-1:0]  i_duty_c,
	input  wire logic [lps_pkg::NCH-1:0]    i_seg_en,
	input  wire logic [1:0]                 i_strategy,
	// Analog status, asynchronous.
	input  wire logic                       i_supply_low_lockout,
	input  wire logic                       i_main_lit,
	// Ambient regulation.
	input  wire logic                       i_photo_active,
	input  wire logic [lps_pkg::CUR_W-1:0]  i_photo_req,
	// Outputs.
	output logic [lps_pkg::REG_W-1:0]       o_floor_rdata,
	output logic                            o_main_en,
	output logic [lps_pkg::NCH-1:0]         o_seg_pwm,
	output logic [lps_pkg::CUR_W-1:0]       o_led_peak_current
);
	import lps_pkg::*;

	// Two-stage synchronisers for the analog flags.
	// Only the second stage feeds logic, so a metastable first stage never fans out.
	logic [1:0] uvlo_sync_q, uvlo_sync_d;  // Lockout synchroniser.
	logic [1:0] lit_sync_q, lit_sync_d;    // Main display status synchroniser.
	logic       uvlo;                      // Synchronised lockout.
	logic       lit;                       // Synchronised main-lit status.

	always_comb begin
		uvlo_sync_d = {uvlo_sync_q[0], i_supply_low_lockout};
		lit_sync_d  = {lit_sync_q[0], i_main_lit};
	end

	// The lockout synchroniser comes up asserted and the lit one cleared, so nothing drives until supply is seen good.
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			uvlo_sync_q <= 2'h3;
			lit_sync_q  <= 2'h0;
		end else begin
			uvlo_sync_q <= uvlo_sync_d;
			lit_sync_q  <= lit_sync_d;
		end
	end
	assign uvlo = uvlo_sync_q[1];
	assign lit  = lit_sync_q[1];

	// Floor register, only the low nibble is stored.
	// The upper nibble is not stored in floor_q and is loaded as zero into the readback register, so it cannot leak into readback.
	logic [FLOOR_W-1:0] floor_q, floor_d; // Floor code.

	always_comb begin
		floor_d = floor_q;
		if (i_floor_we) begin
			floor_d = i_floor_wdata[FLOOR_W-1:0];
		end
	end

	// Sequencer state.
	lps_seq_e  state_q, state_d; // Power-up sequencer.
	logic [4:0] slot_q, slot_d;  // Shared PWM frame slot.
	logic [NCH-1:0] run_q, run_d; // Per-channel running flag.
	logic [NCH-1:0] full_q, full_d; // Channel has completed a full-power frame.
	logic [DUTY_W-1:0] duty [NCH]; // Duty fields, reserved bits dropped.
	logic [NCH-1:0] pwm_d;       // Next PWM output levels.
	logic [CUR_W-1:0] clamp_cur; // Floored current request.
	logic [CUR_W-1:0] cur_d;     // Next current output.
	logic main_d;                // Next main display enable.

	assign duty[0] = i_duty_a[DUTY_W-1:0];
	assign duty[1] = i_duty_b[DUTY_W-1:0];
	assign duty[2] = i_duty_c[DUTY_W-1:0];

	// Main display first, then segment channels; lockout aborts from any state.
	// Leaving lockout always passes through the main state again, so the main display
	// is relit before any segment returns.
	always_comb begin
		state_d = state_q;
		case (state_q)
			SQ_OFF:  if (!uvlo) state_d = SQ_MAIN;
			SQ_MAIN: if (uvlo) state_d = SQ_OFF; else if (lit) state_d = SQ_RUN;
			SQ_RUN:  if (uvlo || !lit) state_d = uvlo ? SQ_OFF : SQ_MAIN;
			default: state_d = SQ_OFF;
		endcase
	end

	// One frame counter, held at zero outside the run state, gives all channels the same edges.
	// It wraps every 32 cycles, which is the PWM frame length.
	always_comb begin
		slot_d = (state_q == SQ_RUN) ? slot_q + 5'h01 : 5'h00;
	end

	// Per-channel enable and PWM compare, one slice per channel.
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic prev_ok; // Chain condition from the preceding channel.
		if (c == 0) begin : g_first
			assign prev_ok = 1'b1;
		end else begin : g_rest
			assign prev_ok = full_q[c-1];
		end

		always_comb begin
			run_d[c]  = 1'b0;
			full_d[c] = 1'b0;
			if (state_q == SQ_RUN) begin
				case (i_strategy)
					STRAT_SYNC:  run_d[c] = &i_seg_en;
					// Chained channels start on a frame boundary, so the frame that sets the
					// full flag is always a whole one at top duty.
					STRAT_CHAIN: run_d[c] = i_seg_en[c] && (run_q[c] || (prev_ok && (slot_d == 5'h00)));
					STRAT_INDEP: run_d[c] = i_seg_en[c];
					default:     run_d[c] = i_seg_en[c];
				endcase
				// Full power is reached once a whole frame ran at top duty.
				full_d[c] = full_q[c] || (run_q[c] && (duty[c] == DUTY_FULL) && (slot_q == SLOT_LAST));
				if (!run_d[c]) full_d[c] = 1'b0;
			end
			// Synchronized mode uses channel zero's duty so timing is identical.
			if (i_strategy == STRAT_SYNC) begin
				pwm_d[c] = run_d[c] && (slot_d < duty[0]);
			end else begin
				pwm_d[c] = run_d[c] && (slot_d < duty[c]);
			end
		end
	end

	// The clamp is combinational; its result is registered with the other outputs.
	lps_floor_clamp i_lps_floor_clamp (
		.i_code   (floor_q),
		.i_req    (i_photo_req),
		.i_active (i_photo_active),
		.o_cur    (clamp_cur)
	);

	// Output next values; lockout forces everything off.
	always_comb begin
		main_d = (state_d != SQ_OFF);
		cur_d  = (state_d == SQ_OFF) ? 8'h00 : clamp_cur;
	end

	// Register all state and outputs.
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			floor_q            <= 4'h0;
			state_q            <= SQ_OFF;
			slot_q             <= 5'h00;
			run_q              <= 3'h0;
			full_q             <= 3'h0;
			o_floor_rdata      <= FLOOR_RESET;
			o_main_en          <= 1'b0;
			o_seg_pwm          <= 3'h0;
			o_led_peak_current <= 8'h00;
		end else begin
			floor_q            <= floor_d;
			state_q            <= state_d;
			slot_q             <= slot_d;
			run_q              <= run_d;
			full_q             <= full_d;
			o_floor_rdata      <= {4'h0, floor_d} & FLOOR_MASK;
			o_main_en          <= main_d;
			o_seg_pwm          <= (state_d == SQ_RUN) ? pwm_d : 3'h0;
			o_led_peak_current <= cur_d;
		end
	end

	// Checks. Each |=> check looks at registered outputs one edge after the inputs that caused them,
	// which matches the single cycle of latency through the output registers.
	a_uvlo_off: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		uvlo |=> (o_seg_pwm == 3'h0) && !o_main_en) else $error("Outputs active during lockout.");
	a_main_first: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(o_seg_pwm != 3'h0) |-> o_main_en && $past(lit)) else $error("Segment on before main display.");
	a_floor_res: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_floor_rdata[7:4] == 4'h0) else $error("Reserved floor bits set.");
	a_floor_wr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_floor_we |=> o_floor_rdata[3:0] == $past(i_floor_wdata[3:0])) else $error("Floor write lost.");
	a_floor_min: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_photo_active && state_d != SQ_OFF) |=> o_led_peak_current >= $past(i_photo_req)
		&& o_led_peak_current != 8'h00) else $error("Current below floor.");
	a_sync_same: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_strategy == STRAT_SYNC) && $stable(i_strategy) |-> (o_seg_pwm == 3'h0 || o_seg_pwm == 3'h7))
		else $error("Synchronized channels differ.");
	a_chain_order: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_strategy == STRAT_CHAIN) && !run_q[0] ##1 (i_strategy == STRAT_CHAIN) |-> !run_q[1])
		else $error("Chained channel started early.");
	a_indep_en: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_strategy == STRAT_INDEP) && !i_seg_en[1] |=> !o_seg_pwm[1]) else $error("Disabled channel ran.");
	a_free_run: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_strategy == STRAT_FREE) && state_q == SQ_RUN && i_seg_en[2] && !uvlo && lit |=> run_q[2])
		else $error("Free channel not running.");
	a_duty_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_strategy == STRAT_INDEP) && duty[2] == 5'h00 |=> !o_seg_pwm[2]) else $error("Zero duty drove pwm.");
	c_run: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) state_q == SQ_RUN);
	c_chain: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) i_strategy == STRAT_CHAIN && run_q[2]);
	c_uvlo: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) state_q == SQ_RUN ##1 state_q == SQ_OFF);
	// A dark main display must also mean no current and no segment drive.
	a_off_dark: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		!o_main_en |-> (o_led_peak_current == 8'h00) && (o_seg_pwm == 3'h0)) else $error("Current flows while off.");
	// Further covers: main display lost while running, and all locked channels lit together.
	c_main_lost: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		state_q == SQ_RUN ##1 state_q == SQ_MAIN);
	c_sync_on: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_strategy == STRAT_SYNC && o_seg_pwm == 3'h7);
endmodule : lps_seq_core

// File: verification/lps_led_sink.sv
// LED segment sink model: counts the lit cycles of each segment string.
// Assumes the PWM levels are registered on the same reference clock.
module lps_led_sink (
	// Clock, reset and clear.
	input  wire logic       i_ref_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clear,
	// Segment drive levels, bit 0 is channel a.
	input  wire logic [2:0] i_seg_pwm,
	// Lit cycle counts since the last clear.
	output logic      [7:0] o_cnt_a,
	output logic      [7:0] o_cnt_b,
	output logic      [7:0] o_cnt_c
);
	timeunit 1ns;
	timeprecision 1ps;
	// A sink conducts only while its level is high, so the count is the light it delivered.
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst || i_clear) begin
			o_cnt_a <= 8'h00;
			o_cnt_b <= 8'h00;
			o_cnt_c <= 8'h00;
		end else begin
			o_cnt_a <= o_cnt_a + 8'(i_seg_pwm[0]);
			o_cnt_b <= o_cnt_b + 8'(i_seg_pwm[1]);
			o_cnt_c <= o_cnt_c + 8'(i_seg_pwm[2]);
		end
	end
endmodule : lps_led_sink

// File: verification/tb_top.sv
// Self-checking bench for the segment sequencer core with a counting LED sink.
// Assumes the design package is compiled first; inputs change on falling edges.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lps_pkg::*;
	logic       i_ref_clk, i_sys_rst, i_floor_we, i_supply_low_lockout, i_main_lit, i_photo_active, clr;
	logic [7:0] i_floor_wdata, i_duty_a, i_duty_b, i_duty_c, i_photo_req, d;
	logic [2:0] i_seg_en;
	logic [1:0] i_strategy;
	logic [7:0] o_floor_rdata, o_led_peak_current, cnt_a, cnt_b, cnt_c;
	logic       o_main_en;
	logic [2:0] o_seg_pwm;
	int         errors, compares, seed;
	lps_seq_core i_lps_seq_core (.i_ref_clk, .i_sys_rst, .i_floor_we, .i_floor_wdata, .i_duty_a, .i_duty_b,
		.i_duty_c, .i_seg_en, .i_strategy, .i_supply_low_lockout, .i_main_lit, .i_photo_active,
		.i_photo_req, .o_floor_rdata, .o_main_en, .o_seg_pwm, .o_led_peak_current);
	lps_led_sink i_lps_led_sink (.i_ref_clk, .i_sys_rst, .i_clear(clr), .i_seg_pwm(o_seg_pwm),
		.o_cnt_a(cnt_a), .o_cnt_b(cnt_b), .o_cnt_c(cnt_c));
	// Free-running 25 MHz reference clock.
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// Lit cycles over two frames for one duty register and enable.
	function automatic logic [7:0] exp_cnt(input logic [7:0] r, input logic en);
		return en ? {2'h0, r[4:0], 1'b0} : 8'h00;
	endfunction : exp_cnt
	// Compares one value and counts it.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask : tick
	// Two whole frames are counted, so the window phase does not matter.
	task automatic measure(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] ec);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(64);
		check(cnt_a, ea);
		check(cnt_b, eb);
		check(cnt_c, ec);
	endtask : measure
	// One write strobe, then a quiet edge so back-to-back writes never retoggle it in one step.
	task automatic wr(input logic [7:0] v);
		i_floor_we    = 1'b1;
		i_floor_wdata = v;
		tick(1);
		i_floor_we    = 1'b0;
		tick(1);
	endtask : wr
	task automatic give_verdict();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// Watchdog: the sequence needs about 1300 cycles.
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		errors++;
		give_verdict();
	end
	// Main sequence.
	initial begin
		seed = 40616;
		{i_floor_we, i_supply_low_lockout, i_photo_active, clr, i_floor_wdata, i_photo_req} = '0;
		{i_duty_a, i_duty_b, i_duty_c, i_seg_en, i_strategy} = '0;
		i_main_lit = 1'b1;
		i_sys_rst  = 1'b1;
		tick(3);
		check(o_floor_rdata, 8'h00);
		i_sys_rst = 1'b0;
		tick(4);
		check({7'h0, o_main_en}, 8'h01);
		for (int k = 0; k < 8; k++) begin
			d = 8'($random(seed));
			wr(d);
			check(o_floor_rdata, d & 8'h0f);
		end
		// The highest floor code lifts a zero request to full scale.
		i_photo_active = 1'b1;
		wr(8'hff);
		tick(3);
		check(o_led_peak_current, 8'hff);
		wr(8'h00);
		for (int k = 0; k < 6; k++) begin
			i_photo_req = (k == 0) ? 8'h00 : 8'($random(seed));
			tick(3);
			check(o_led_peak_current, (i_photo_req == 8'h00) ? 8'h01 : i_photo_req);
		end
		// Without regulation the floor does not apply, so a small request passes unchanged.
		wr(8'h0f);
		i_photo_active = 1'b0;
		i_photo_req    = 8'h02;
		tick(3);
		check(o_led_peak_current, 8'h02);
		i_photo_active = 1'b1;
		// Locked channels all follow channel a, whatever b and c hold.
		{i_duty_a, i_duty_b, i_duty_c} = 24'($random(seed));
		i_seg_en   = 3'h7;
		i_strategy = STRAT_SYNC;
		tick(40);
		measure(exp_cnt(i_duty_a, 1'b1), exp_cnt(i_duty_a, 1'b1), exp_cnt(i_duty_a, 1'b1));
		// Chain start: later channels stay dark for the first 20 edges after the enables rise.
		i_seg_en   = 3'h0;
		{i_duty_a, i_duty_b, i_duty_c} = {3{8'h1f}};
		i_strategy = STRAT_CHAIN;
		tick(40);
		i_seg_en = 3'h7;
		for (int k = 0; k < 20; k++) begin
			tick(1);
			check({6'h0, o_seg_pwm[2:1]}, 8'h00);
		end
		tick(200);
		measure(8'h3e, 8'h3e, 8'h3e);
		// Independent and free modes with random duties, reserved bits and enables.
		for (int k = 0; k < 6; k++) begin
			i_strategy = (k < 3) ? STRAT_INDEP : STRAT_FREE;
			{i_duty_a, i_duty_b, i_duty_c} = 24'($random(seed));
			i_seg_en = (k == 0) ? 3'h2 : 3'($random(seed));
			tick(40);
			measure(exp_cnt(i_duty_a, i_seg_en[0]), exp_cnt(i_duty_b, i_seg_en[1]), exp_cnt(i_duty_c, i_seg_en[2]));
		end
		// Losing the main display darkens every segment.
		i_seg_en   = 3'h7;
		i_main_lit = 1'b0;
		tick(5);
		measure(8'h00, 8'h00, 8'h00);
		check({7'h0, o_main_en}, 8'h01);
		i_main_lit = 1'b1;
		tick(5);
		// Lockout shuts everything within three edges and holds it off.
		i_supply_low_lockout = 1'b1;
		tick(3);
		check({o_led_peak_current | {4'h0, o_main_en, o_seg_pwm}}, 8'h00);
		measure(8'h00, 8'h00, 8'h00);
		i_supply_low_lockout = 1'b0;
		tick(5);
		check({7'h0, o_main_en}, 8'h01);
		give_verdict();
	end
endmodule : tb_top
